// ---- comp_model.sv ----
/*
  Comparator model standing where the capacitor arrays meet the comparator.
  Assumes the held input is a signed level in code steps and that the
  control samples the decision on its own conversion ticks.
*/
`timescale 1ns/1ps
`default_nettype none
module comp_model (
  input wire logic [15:0] trial_i,
  input wire logic signed [17:0] level_i,
  output logic keep_o
);
  // Keep the trial bit while the trial code does not pass the input
  assign keep_o = level_i >= $signed({2'b00, trial_i});
endmodule
`default_nettype wire

// ---- conv_clock_div.sv ----
/*
  Divider that produces the internal conversion clock as an enable pulse.
  Assumes the pulse only runs while the converter is powered.
*/
`timescale 1ns/1ps
`default_nettype none
module conv_clock_div (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic run_i,
  output logic tick_o
);

  logic [sar_pkg::DIV_W-1:0] cnt_r;
  wire last_w = (cnt_r == sar_pkg::DIV_W'(sar_pkg::CONV_DIV - 1));

  always_ff @(posedge clk_i) begin
    if (!nrst_i || !run_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= last_w ? '0 : cnt_r + 1'b1;
    end
  end

  assign tick_o = run_i && last_w;

endmodule
`default_nettype wire

// ---- sar_conversion_control.sv ----
/*
  Control logic of a 16-bit successive-approximation converter: start
  on convert edge, switch sequencing, bitwise trials, result and done.
  Assumes the comparator output is synchronous and settled on each
  conversion tick; convert_start comes from a logic host.
*/
// Contract
// R1: Host raises convert_start after acquisition; rising edge begins conversion.
// R2: Open both comparator ground switches, then move arrays to ground.
// R3: Sixteen binary-weighted trials from MSB, keep bit per comparator decision.
// R4: After trials, return to acquisition, present code, pulse done.
// R5: Steps are timed by internal conversion clock, not the serial clock.
// R6: Presented result belongs to the conversion just finished.
// R7: Back-to-back conversions reach 500 kSPS.
// R8: Conversion circuitry powers down by itself between conversions.
// R9: Output is 16-bit straight binary.
// R10: Over-range input saturates at all ones, never wraps.
// R11: Under-range input saturates at all zeros.
// R12: Convert edges during a conversion are ignored.
`timescale 1ns/1ps
`default_nettype none
module sar_conversion_control (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic convert_start_i,
  input wire logic comp_high_i,
  output sar_pkg::switch_ctrl_type sw_o,
  output logic [15:0] result_o,
  output logic done_o,
  output logic busy_o
);

  sar_pkg::conv_state_type state_r, state_nxt;
  logic cnv_d_r;
  logic [15:0] trial_r, trial_nxt;
  logic [15:0] mask_r, mask_nxt;
  logic [15:0] result_r;
  logic done_r;
  logic tick_w;

  wire start_w = convert_start_i && !cnv_d_r;
  wire idle_w = (state_r == sar_pkg::ST_ACQUIRE);
  wire run_w = !idle_w;
  wire last_trial_w = mask_r[0];

  // Keep trial bit when the comparator says the array still undershoots
  function automatic logic [15:0] decide(input logic [15:0] t,
                                         input logic [15:0] m,
                                         input logic hi);
    decide = hi ? t : (t & ~m);
  endfunction

  conv_clock_div i_conv_clock_div ( // R5 R7
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .run_i(run_w),
    .tick_o(tick_w)
  );

  always_comb begin
    state_nxt = state_r;
    trial_nxt = trial_r;
    mask_nxt = mask_r;
    case (state_r)
      sar_pkg::ST_ACQUIRE: begin
        if (start_w) begin // R1 R12
          state_nxt = sar_pkg::ST_OPEN_GND;
        end
      end
      sar_pkg::ST_OPEN_GND: begin
        if (tick_w) begin // R2 R5
          state_nxt = sar_pkg::ST_TO_GROUND;
        end
      end
      sar_pkg::ST_TO_GROUND: begin
        if (tick_w) begin // R2
          state_nxt = sar_pkg::ST_TRIAL;
          trial_nxt = sar_pkg::CODE_MID;
          mask_nxt = sar_pkg::CODE_MID;
        end
      end
      sar_pkg::ST_TRIAL: begin
        if (tick_w) begin // R3 R5
          trial_nxt = decide(trial_r, mask_r, comp_high_i);
          mask_nxt = mask_r >> 1;
          trial_nxt = trial_nxt | (mask_r >> 1);
          if (last_trial_w) begin
            state_nxt = sar_pkg::ST_DONE;
          end
        end
      end
      sar_pkg::ST_DONE: begin
        state_nxt = sar_pkg::ST_ACQUIRE; // R4
      end
      default: begin
        state_nxt = sar_pkg::ST_ACQUIRE;
      end
    endcase
  end

  // Over-range keeps every trial bit and under-range clears every bit,
  // so saturation falls out of the search without wrap
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state_r <= sar_pkg::ST_ACQUIRE;
      cnv_d_r <= 1'b0;
      trial_r <= sar_pkg::CODE_ZERO;
      mask_r <= sar_pkg::CODE_ZERO;
      result_r <= sar_pkg::CODE_ZERO;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnv_d_r <= convert_start_i;
      trial_r <= trial_nxt;
      mask_r <= mask_nxt;
      done_r <= (state_r == sar_pkg::ST_DONE); // R4
      if (state_r == sar_pkg::ST_DONE) begin
        result_r <= trial_r; // R6 R9 R10 R11
      end
    end
  end

  // Switch controls follow the phase; idle closes both ground switches and puts the arrays on the input
  assign sw_o.pos_gnd_sw = idle_w; // R2
  assign sw_o.neg_gnd_sw = idle_w;
  assign sw_o.arrays_to_input = idle_w || state_r == sar_pkg::ST_OPEN_GND;
  assign sw_o.arrays_to_ground = !sw_o.arrays_to_input;
  assign sw_o.dac_bits = (state_r == sar_pkg::ST_TRIAL) ? trial_r : '0;
  assign sw_o.powered = run_w; // R8
  assign result_o = result_r;
  assign done_o = done_r;
  assign busy_o = run_w;

  AST_START_TAKEN: assert property (@(posedge clk_i) disable iff (!nrst_i) // R1
    idle_w && start_w |=> state_r == sar_pkg::ST_OPEN_GND)
    else $error("convert edge not taken");

  AST_GND_BEFORE_ARRAYS: assert property (@(posedge clk_i) // R2
    disable iff (!nrst_i)
    state_r == sar_pkg::ST_OPEN_GND |-> !sw_o.pos_gnd_sw && !sw_o.neg_gnd_sw
      && sw_o.arrays_to_input)
    else $error("arrays moved before ground switches opened");

  AST_MSB_FIRST: assert property (@(posedge clk_i) disable iff (!nrst_i) // R3
    $rose(state_r == sar_pkg::ST_TRIAL) |-> mask_r == sar_pkg::CODE_MID)
    else $error("first trial is not the MSB");

  AST_DONE_RETURN: assert property (@(posedge clk_i) disable iff (!nrst_i) // R4
    done_o |-> idle_w && $past(state_r) == sar_pkg::ST_DONE)
    else $error("done without return to acquisition");

  AST_CONV_TIME: assert property (@(posedge clk_i) disable iff (!nrst_i) // R7
    $rose(busy_o) |-> ##[1:80] done_o)
    else $error("conversion too slow for full throughput");

  AST_POWER_DOWN: assert property (@(posedge clk_i) disable iff (!nrst_i) // R8
    done_o |-> !sw_o.powered && sw_o.dac_bits == 16'h0000)
    else $error("circuitry still powered after conversion");

  AST_SATURATE_HIGH: assert property (@(posedge clk_i) // R10
    disable iff (!nrst_i)
    state_r == sar_pkg::ST_TRIAL && tick_w && comp_high_i && trial_r == 16'hFFFF
      && last_trial_w |=> trial_r == 16'hFFFF)
    else $error("over-range result wrapped");

  AST_RESULT_FRESH: assert property (@(posedge clk_i) disable iff (!nrst_i) // R6
    done_o |-> result_o == $past(trial_r))
    else $error("result is not from this conversion");

  AST_IGNORE_RESTART: assert property (@(posedge clk_i) // R12
    disable iff (!nrst_i)
    state_r == sar_pkg::ST_TRIAL && !tick_w |=> state_r == sar_pkg::ST_TRIAL)
    else $error("conversion disturbed");

  AST_NO_RESTART: assert property (@(posedge clk_i) // R12
    disable iff (!nrst_i)
    start_w && (state_r == sar_pkg::ST_TO_GROUND
      || state_r == sar_pkg::ST_TRIAL) |=> busy_o
      && state_r != sar_pkg::ST_OPEN_GND)
    else $error("convert edge restarted a running conversion");

  AST_SIXTEEN_TRIALS: assert property (@(posedge clk_i) // R3 R5
    disable iff (!nrst_i)
    $rose(state_r == sar_pkg::ST_TRIAL) |-> ##64
      state_r == sar_pkg::ST_DONE)
    else $error("trial phase did not last sixteen ticks");

  AST_TRIAL_HOLD: assert property (@(posedge clk_i) // R3 R5
    disable iff (!nrst_i)
    state_r == sar_pkg::ST_TRIAL && !tick_w |=> $stable(trial_r)
      && $stable(mask_r))
    else $error("trial changed between conversion ticks");

  AST_KEEP_BIT: assert property (@(posedge clk_i) // R3
    disable iff (!nrst_i)
    state_r == sar_pkg::ST_TRIAL && tick_w && comp_high_i
      |=> (trial_r & $past(mask_r)) != 16'h0000)
    else $error("kept trial bit was lost");

  AST_CLEAR_BIT: assert property (@(posedge clk_i) // R3
    disable iff (!nrst_i)
    state_r == sar_pkg::ST_TRIAL && tick_w && !comp_high_i
      |=> (trial_r & $past(mask_r)) == 16'h0000)
    else $error("rejected trial bit was kept");

  AST_SATURATE_LOW: assert property (@(posedge clk_i) // R11
    disable iff (!nrst_i)
    state_r == sar_pkg::ST_TRIAL && tick_w && !comp_high_i
      && trial_r == 16'h0001 && last_trial_w |=> trial_r == 16'h0000)
    else $error("under-range result did not clear");

  AST_IDLE_SWITCHES: assert property (@(posedge clk_i) // R2 R8
    disable iff (!nrst_i)
    idle_w |-> sw_o.pos_gnd_sw && sw_o.neg_gnd_sw && !sw_o.arrays_to_ground
      && !sw_o.powered && sw_o.dac_bits == 16'h0000)
    else $error("switches not in acquisition setting while idle");

  AST_GND_OPEN_FIRST: assert property (@(posedge clk_i) // R2
    disable iff (!nrst_i)
    $rose(sw_o.arrays_to_ground) |-> !$past(sw_o.pos_gnd_sw)
      && !$past(sw_o.neg_gnd_sw))
    else $error("arrays grounded before ground switches opened");

  AST_TICK_WHILE_RUN: assert property (@(posedge clk_i) // R5 R8
    disable iff (!nrst_i)
    tick_w |-> run_w)
    else $error("conversion tick while powered down");

  AST_DONE_PULSE: assert property (@(posedge clk_i) // R4
    disable iff (!nrst_i)
    done_o |=> !done_o)
    else $error("done held longer than one cycle");

  AST_RESULT_HOLD: assert property (@(posedge clk_i) // R6
    disable iff (!nrst_i)
    !done_o |-> $stable(result_o))
    else $error("result changed without a finished conversion");

endmodule
`default_nettype wire

// ---- sar_conversion_control_bench.sv ----
/*
  Self-checking bench of the conversion control with a comparator model.
  Assumes the 200 MHz clock, synchronous active-low reset and the
  switch carrier of the package.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module sar_conversion_control_bench;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic convert_start_i = 1'b0;
  logic signed [17:0] level = 18'sh0;
  logic comp_high;
  sar_pkg::switch_ctrl_type sw_o;
  logic [15:0] result_o;
  logic done_o;
  logic busy_o;
  int miscompares = 0;
  int checked = 0;
  logic [15:0] codes [6] = '{16'h0000, 16'h8000, 16'h8001, 16'h7FFF,
    16'h0001, 16'hFFFF};
  always #2.5 clk_i = ~clk_i;
  sar_conversion_control i_sar_conversion_control (.clk_i(clk_i),
    .nrst_i(nrst_i), .convert_start_i(convert_start_i),
    .comp_high_i(comp_high), .sw_o(sw_o), .result_o(result_o),
    .done_o(done_o), .busy_o(busy_o));
  comp_model i_comp_model (.trial_i(sw_o.dac_bits), .level_i(level),
    .keep_o(comp_high));
  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask
  task automatic test_done();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic guard(input int n, input int bound);
    if (n >= bound) begin
      miscompares++;
      $display("unexpected at %0t: wait ran out", $time);
      test_done();
    end
  endtask
  // One conversion; glitch re-pulses the convert input mid-conversion
  task automatic run(input logic signed [17:0] lvl, input logic [15:0] exp,
    input bit glitch);
    int n;
    n = 0;
    @(posedge clk_i);
    level <= lvl;
    convert_start_i <= 1'b1;
    while (busy_o !== 1'b1 && n < 8) begin tick(); n++; end
    guard(n, 8);
    `CHK({sw_o.pos_gnd_sw, sw_o.neg_gnd_sw, sw_o.arrays_to_ground}, 3'h0)
    `CHK(sw_o.powered, 1'b1)
    while (sw_o.arrays_to_ground !== 1'b1 && n < 40) begin tick(); n++; end
    guard(n, 40);
    `CHK({sw_o.pos_gnd_sw, sw_o.neg_gnd_sw, sw_o.arrays_to_input}, 3'h0)
    while (sw_o.dac_bits === 16'h0000 && n < 40) begin tick(); n++; end
    guard(n, 40);
    `CHK(sw_o.dac_bits, sar_pkg::CODE_MID)
    if (glitch) begin
      @(posedge clk_i);
      convert_start_i <= 1'b0;
      @(posedge clk_i);
      convert_start_i <= 1'b1;
      n += 2;
    end
    while (done_o !== 1'b1 && n < 500) begin tick(); n++; end
    guard(n, 500);
    `CHK(n <= sar_pkg::MIN_PERIOD_CYC, 1'b1)
    `CHK(result_o, exp)
    `CHK({busy_o, sw_o.arrays_to_input}, 2'h1)
    tick();
    `CHK({busy_o, done_o, sw_o.powered}, 3'h0)
    `CHK(result_o, exp)
    @(posedge clk_i);
    convert_start_i <= 1'b0;
  endtask
  task automatic test_codes();
    foreach (codes[i]) run($signed({2'b00, codes[i]}), codes[i], 1'b0);
    $display("test codes done");
  endtask
  task automatic test_range();
    run(18'sh1FFFF, 16'hFFFF, 1'b0);
    run(-18'sd5, 16'h0000, 1'b0);
    $display("test range done");
  endtask
  task automatic test_refusal();
    run(18'sh0A5C3, 16'hA5C3, 1'b1);
    run(18'sh05A3C, 16'h5A3C, 1'b1);
    $display("test refusal done");
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'b1;
    tick();
    `CHK({busy_o, done_o, sw_o.powered, sw_o.arrays_to_input}, 4'h1)
    test_codes();
    test_range();
    test_refusal();
    test_done();
  end
endmodule
`default_nettype wire

// ---- sar_pkg.sv ----
/*
  Shared constants and carrier types for the successive-approximation
  conversion control.
  Assumes a single 200 MHz clock and synchronous active-low reset.
*/
package sar_pkg;

  localparam int unsigned RES_BITS = 16;
  localparam int unsigned CLK_MHZ = 200;

  // Shortest conversion period at the top throughput, in ns
  localparam int unsigned MIN_PERIOD_NS = 2000;
  localparam int unsigned MIN_PERIOD_CYC = MIN_PERIOD_NS * CLK_MHZ / 1000;

  // Conversion clock: one enable pulse every CONV_DIV system cycles
  localparam int unsigned CONV_DIV = 4;
  localparam int unsigned DIV_W = 2;

  // Settling steps after the ground switches open
  localparam int unsigned SETTLE_STEPS = 1;

  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] CODE_MID = 16'h8000;
  localparam logic [15:0] CODE_FULL = 16'hFFFF;

  typedef enum logic [2:0] {
    ST_ACQUIRE,
    ST_OPEN_GND,
    ST_TO_GROUND,
    ST_TRIAL,
    ST_DONE
  } conv_state_type;

  // Analog switch controls toward the capacitor arrays
  typedef struct packed {
    logic pos_gnd_sw;
    logic neg_gnd_sw;
    logic arrays_to_input;
    logic arrays_to_ground;
    logic [15:0] dac_bits;
    logic powered;
  } switch_ctrl_type;

endpackage
